/* pkg/irq_ctrl_params.svh */
// constants for the prioritized interrupt controller
// assumes: included by bare name from pkg, rtl and sim files
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH
`define NUM_SRC        54
`define LAST_SRC       53
`define VEC_OFS        7'h08
`define TABLE_ENTRIES  62
`define ADDR_W         24
// table base is arbitrary; alternate table sits right after it
`define VT_BASE        24'h000000
`define ALT_OFS        24'h00007c
`define EXT0_NUM       0
`define EXT1_NUM       16
`define EXT2_NUM       23
`define BUS_SLAVE_NUM  13
`define BUS_MASTER_NUM 14
`define IMPL_MASK      54'h0004000b81ffff
`define PRIO_RST       3'h4
`endif

/* pkg/irq_ctrl_pkg.sv */
// types shared by the interrupt controller
// assumes: irq_ctrl_params.svh is on the include path
`include "irq_ctrl_params.svh"
package irq_ctrl_pkg;
    typedef logic [15:0] word_t;
    typedef struct packed {
        logic       alt_table_select;
        logic [2:0] external_edge_polarity_bits;
    } second_irq_control_s;
    typedef struct packed {
        logic dc;
        logic n;
        logic ov;
        logic z;
        logic c;
    } cpu_flag_register_s;
    typedef struct packed {
        word_t w3;
        word_t w2;
        word_t w1;
        word_t w0;
    } work_regs_s;
    typedef struct packed {
        logic       en;
        logic [5:0] idx;
        logic [3:0] nibble;
    } prio_wr_s;
    typedef struct packed {
        logic       valid;
        logic [2:0] prio;
        logic [5:0] num;
    } cand_s;
endpackage

/* rtl/prioritized_interrupt_controller.sv */
// prioritized interrupt controller: pending flags, arbitration, vectors,
// external edge requests, wake-up and one-level shadow registers
// assumes: all inputs synchronous to i_clk_sys, event inputs are pulses
//
// Contract
// - priority nibble holds 3-bit level in low bits; bit 3 reads zero
// - level 0 ranks lowest and level 7 ranks highest
// - user level outranks fixed order
// - equal levels pending together: earlier table position wins
// - fixed order runs 0 (highest) to 53 (lowest), equal to number
// - vector number equals interrupt number plus eight
// - source numbers fixed; reserved numbers never become pending
// - alternate-table select moves every vector fetch to alternate table
// - alternate table follows default table with identical layout
// - one-level shadow of five flags and working registers 0 to 3
// - shadows reached only by push and pop; push copies current values
// - external requests raised on transitions only, never on levels
// - three polarity bits choose rising or falling edge per input
// - qualifying request during sleep or idle also wakes processor
// - bus master flag set when master message event completes
// - bus slave flag set on message addressed to this slave
`timescale 1ns/1ns
`include "irq_ctrl_params.svh"
`default_nettype none
module prioritized_interrupt_controller (
    input  wire logic                             i_clk_sys,
    input  wire logic                             i_rst_n,
    input  wire logic [`LAST_SRC:0]               i_periph_evt,
    input  wire logic [2:0]                       i_external_request_inputs,
    input  wire irq_ctrl_pkg::second_irq_control_s i_second_irq_control,
    input  wire logic                             i_bus_master_event,
    input  wire logic                             i_bus_slave_event,
    input  wire logic [`LAST_SRC:0]               i_pend_clr,
    input  wire logic [`LAST_SRC:0]               i_irq_enable,
    input  wire irq_ctrl_pkg::prio_wr_s           i_prio_wr,
    input  wire logic [5:0]                       i_prio_rd_idx,
    input  wire logic [2:0]                       i_cpu_ipl,
    input  wire logic                             i_sleep,
    input  wire logic                             i_idle,
    input  wire logic [2:0]                       i_trap_num,
    input  wire logic                             i_push_shadow,
    input  wire logic                             i_pop_shadow,
    input  wire irq_ctrl_pkg::cpu_flag_register_s i_cpu_flags,
    input  wire irq_ctrl_pkg::work_regs_s         i_work_regs,
    output logic [`LAST_SRC:0]                    o_pending,
    output logic [3:0]                            o_prio_rd,
    output logic                                  o_irq_req,
    output logic [5:0]                            o_irq_num,
    output logic [6:0]                            o_vector_num,
    output logic [`ADDR_W-1:0]                    o_vector_addr,
    output logic [`ADDR_W-1:0]                    o_trap_addr,
    output logic                                  o_wake,
    output irq_ctrl_pkg::cpu_flag_register_s      o_shadow_flags,
    output irq_ctrl_pkg::work_regs_s              o_shadow_regs,
    output logic                                  o_shadow_restore
);
    import irq_ctrl_pkg::*;

    // ************************************************************
    // external edge detection
    // ************************************************************
    logic [2:0] ext_prev_r;
    wire  [2:0] ext_rise = i_external_request_inputs & ~ext_prev_r;
    wire  [2:0] ext_fall = ~i_external_request_inputs & ext_prev_r;
    wire  [2:0] ext_pol  = i_second_irq_control.external_edge_polarity_bits;
    // polarity 0 selects rising, 1 selects falling; levels never request
    wire  [2:0] ext_edge = (ext_pol & ext_fall) | (~ext_pol & ext_rise);

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ext_prev_r <= 3'h0;
        else
            ext_prev_r <= i_external_request_inputs;
    end

    // ************************************************************
    // pending flags and priority storage
    // ************************************************************
    logic [`LAST_SRC:0] pend_r;
    logic [`LAST_SRC:0] pend_nxt;
    logic [`LAST_SRC:0] hw_set;
    logic [2:0]         prio_r [`NUM_SRC];
    wire  [`LAST_SRC:0] active = pend_r & i_irq_enable;
    cand_s              cand [`NUM_SRC+1];

    assign cand[`NUM_SRC] = '0;

    localparam logic [`LAST_SRC:0] impl_set = `IMPL_MASK;
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_SRC; gi = gi + 1)
        begin : g_src
            wire ext_hit = (gi == `EXT0_NUM) ? ext_edge[0] :
                           (gi == `EXT1_NUM) ? ext_edge[1] :
                           (gi == `EXT2_NUM) ? ext_edge[2] : 1'b0;
            wire bus_hit = (gi == `BUS_MASTER_NUM) ? i_bus_master_event :
                           (gi == `BUS_SLAVE_NUM)  ? i_bus_slave_event  :
                           1'b0;
            wire impl    = impl_set[gi];
            assign hw_set[gi] = impl & (i_periph_evt[gi] | ext_hit | bus_hit);
            // set wins over a clear in the same cycle
            assign pend_nxt[gi] = hw_set[gi] | (pend_r[gi] & ~i_pend_clr[gi]);

            always_ff @(posedge i_clk_sys or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    prio_r[gi] <= `PRIO_RST;
                else if (i_prio_wr.en && i_prio_wr.idx == 6'(gi))
                    prio_r[gi] <= i_prio_wr.nibble[2:0];
            end

            // chain from 53 down to 0; >= lets the lower number take ties
            wire take = active[gi] &&
                        (!cand[gi+1].valid || prio_r[gi] >= cand[gi+1].prio);
            assign cand[gi] = take ? {1'b1, prio_r[gi], 6'(gi)} : cand[gi+1];
        end
    endgenerate

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pend_r <= '0;
        else
            pend_r <= pend_nxt;
    end

    // ************************************************************
    // priority read-back
    // ************************************************************
    wire       rd_ok  = i_prio_rd_idx <= 6'(`LAST_SRC);
    wire [2:0] rd_lvl = rd_ok ? prio_r[i_prio_rd_idx] : 3'h0;
    logic [3:0] prio_rd_r;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            prio_rd_r <= 4'h0;
        else
            prio_rd_r <= {1'b0, rd_lvl};
    end

    // ************************************************************
    // request, vector and wake outputs
    // ************************************************************
    wire        win_ok   = cand[0].valid && (cand[0].prio > i_cpu_ipl);
    wire [6:0]  vec_nxt  = {1'b0, cand[0].num} + `VEC_OFS;
    // alternate table has the same layout, one table further on
    wire [`ADDR_W-1:0] tbl_base = i_second_irq_control.alt_table_select ?
                                  `VT_BASE + `ALT_OFS : `VT_BASE;
    wire [`ADDR_W-1:0] vaddr_nxt = tbl_base + {16'h0, vec_nxt, 1'b0};
    wire [`ADDR_W-1:0] taddr_nxt = tbl_base + {20'h0, i_trap_num, 1'b0};
    wire               wake_nxt  = win_ok && (i_sleep || i_idle);

    logic              irq_req_r;
    logic [5:0]        irq_num_r;
    logic [6:0]        vec_num_r;
    logic [`ADDR_W-1:0] vaddr_r;
    logic [`ADDR_W-1:0] taddr_r;
    logic              wake_r;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            irq_req_r <= 1'b0;
            irq_num_r <= 6'h00;
            vec_num_r <= 7'h00;
            vaddr_r   <= '0;
            taddr_r   <= '0;
            wake_r    <= 1'b0;
        end
        else
        begin
            irq_req_r <= win_ok;
            irq_num_r <= cand[0].num;
            vec_num_r <= vec_nxt;
            vaddr_r   <= vaddr_nxt;
            taddr_r   <= taddr_nxt;
            wake_r    <= wake_nxt;
        end
    end

    // ************************************************************
    // shadow registers
    // ************************************************************
    cpu_flag_register_s sh_flags_r;
    work_regs_s         sh_regs_r;
    logic               restore_r;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sh_flags_r <= '0;
            sh_regs_r  <= '0;
            restore_r  <= 1'b0;
        end
        else
        begin
            restore_r <= i_pop_shadow;
            if (i_push_shadow)
            begin
                sh_flags_r <= i_cpu_flags;
                sh_regs_r  <= i_work_regs;
            end
        end
    end

    assign o_pending        = pend_r;
    assign o_prio_rd        = prio_rd_r;
    assign o_irq_req        = irq_req_r;
    assign o_irq_num        = irq_num_r;
    assign o_vector_num     = vec_num_r;
    assign o_vector_addr    = vaddr_r;
    assign o_trap_addr      = taddr_r;
    assign o_wake           = wake_r;
    assign o_shadow_flags   = sh_flags_r;
    assign o_shadow_regs    = sh_regs_r;
    assign o_shadow_restore = restore_r;

    // ************************************************************
    // assertions
    // ************************************************************
    logic [`LAST_SRC:0] beaten;
    generate
        for (gi = 0; gi < `NUM_SRC; gi = gi + 1)
        begin : g_chk
            assign beaten[gi] = active[gi] && cand[0].valid &&
                ((prio_r[gi] > cand[0].prio) ||
                 (prio_r[gi] == cand[0].prio && 6'(gi) < cand[0].num));
        end
    endgenerate

    property p_winner_best;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        cand[0].valid |-> (beaten == '0) && active[cand[0].num];
    endproperty
    a_winner_best: assert property (p_winner_best)
        else $error("arbitration winner is beaten by another source");

    property p_req_level;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_irq_req |-> $past(cand[0].prio) > $past(i_cpu_ipl) &&
                      $past(cand[0].num) == o_irq_num;
    endproperty
    a_req_level: assert property (p_req_level)
        else $error("request forwarded without exceeding cpu level");

    property p_vector_ofs;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_irq_req |-> o_vector_num == {1'b0, o_irq_num} + `VEC_OFS;
    endproperty
    a_vector_ofs: assert property (p_vector_ofs)
        else $error("vector number is not interrupt number plus eight");

    property p_alt_table;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $past(i_second_irq_control.alt_table_select) |->
            o_vector_addr == `VT_BASE + `ALT_OFS + {16'h0, o_vector_num, 1'b0};
    endproperty
    a_alt_table: assert property (p_alt_table)
        else $error("alternate table not used when selected");

    property p_reserved;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_pending & ~`IMPL_MASK) == '0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved source became pending");

    property p_nibble_msb;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_prio_wr.en ##1 (i_prio_rd_idx == $past(i_prio_wr.idx) && !i_prio_wr.en)
            |=> o_prio_rd == {1'b0, $past(i_prio_wr.nibble[2:0], 2)} ||
                $past(i_prio_wr.idx, 2) > 6'(`LAST_SRC);
    endproperty
    a_nibble_msb: assert property (p_nibble_msb)
        else $error("priority read-back wrong or bit 3 set");

    property p_master_flag;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_bus_master_event |=> o_pending[`BUS_MASTER_NUM];
    endproperty
    a_master_flag: assert property (p_master_flag)
        else $error("bus master event did not set its flag");

    property p_slave_flag;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_bus_slave_event |=> o_pending[`BUS_SLAVE_NUM];
    endproperty
    a_slave_flag: assert property (p_slave_flag)
        else $error("bus slave event did not set its flag");

    property p_ext_edge;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (!ext_pol[0] && $rose(i_external_request_inputs[0])) ||
        (ext_pol[0] && $fell(i_external_request_inputs[0]))
            |=> o_pending[`EXT0_NUM];
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("selected edge on external input 0 not caught");

    property p_pend_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_pending[`EXT0_NUM] && !i_pend_clr[`EXT0_NUM] |=> o_pending[`EXT0_NUM];
    endproperty
    a_pend_hold: assert property (p_pend_hold)
        else $error("pending flag dropped without a clear");

    property p_wake;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_sleep || i_idle) && win_ok |=> o_wake && o_irq_req;
    endproperty
    a_wake: assert property (p_wake)
        else $error("qualifying request during sleep did not wake");

    property p_push;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_push_shadow ##1 !i_push_shadow [*2] |->
            o_shadow_flags == $past(i_cpu_flags, 2) &&
            o_shadow_regs == $past(i_work_regs, 2);
    endproperty
    a_push: assert property (p_push)
        else $error("shadow copy lost or changed without push");
endmodule // prioritized_interrupt_controller
`default_nettype wire

/* sim/irq_core_sleep_model.sv */
// core-side model: sleep state of the processor in front of the controller
// assumes: wake comes from the controller, sleep is commanded by the bench
`timescale 1ns/1ns
`default_nettype none
module irq_core_sleep_model (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_go_sleep,
    input  wire logic i_wake,
    output var logic  o_sleep
);
    // ****************************************
    // sleep state
    // ****************************************
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_sleep <= 1'b0;
        else if (i_wake)
            o_sleep <= 1'b0;
        else if (i_go_sleep)
            o_sleep <= 1'b1;
    end
endmodule // irq_core_sleep_model
`default_nettype wire

/* sim/prioritized_interrupt_controller_test.sv */
// self-checking bench for the prioritized interrupt controller
// assumes: inputs change on the falling edge, outputs read there too
`timescale 1ns/1ns
`include "irq_ctrl_params.svh"
`default_nettype none
module prioritized_interrupt_controller_test;
    import irq_ctrl_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, mev = 1'b0, sev = 1'b0, idle = 1'b0;
    logic push = 1'b0, pop = 1'b0, gsl = 1'b0;
    logic [53:0] evt = '0, clr = '0, en = '0, pend;
    logic [5:0] rdi = '0, num;
    logic [2:0] ipl = '0, ext = '0, trap = '0;
    logic [3:0] prd;
    logic [6:0] vec;
    logic [23:0] vad, tad;
    logic req, wake, rsto, slp;
    second_irq_control_s ctl = '0;
    prio_wr_s wr = '0;
    cpu_flag_register_s flg = '0, sfl;
    work_regs_s wrg = '0, srg;
    int fails = 0, n_checks = 0;
    initial forever #5 clk = ~clk;
    prioritized_interrupt_controller u_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_periph_evt(evt), .i_external_request_inputs(ext), .i_second_irq_control(ctl),
        .i_bus_master_event(mev), .i_bus_slave_event(sev), .i_pend_clr(clr),
        .i_irq_enable(en), .i_prio_wr(wr), .i_prio_rd_idx(rdi), .i_cpu_ipl(ipl),
        .i_sleep(slp), .i_idle(idle), .i_trap_num(trap), .i_push_shadow(push),
        .i_pop_shadow(pop), .i_cpu_flags(flg), .i_work_regs(wrg), .o_pending(pend),
        .o_prio_rd(prd), .o_irq_req(req), .o_irq_num(num), .o_vector_num(vec),
        .o_vector_addr(vad), .o_trap_addr(tad), .o_wake(wake), .o_shadow_flags(sfl),
        .o_shadow_regs(srg), .o_shadow_restore(rsto));
    irq_core_sleep_model u_core (.i_clk_sys(clk), .i_rst_n(rst_n), .i_go_sleep(gsl),
        .i_wake(wake), .o_sleep(slp));
    // ****************************************
    // helpers
    // ****************************************
    task automatic tick(input int n = 1);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrp(input logic [5:0] idx, input logic [3:0] nib);
        wr = '{1'b1, idx, nib};
        rdi = idx;
        tick();
        wr.en = 1'b0;
        tick();
    endtask
    task automatic pulse_clear_all();
        clr = '1;
        tick();
        clr = '0;
        tick();
    endtask
    task automatic stop_test();
        if (fails == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_prio();
        wrp(6'h07, 4'hf);
        tick(2);
        chk("prio_rd_7", 64'(prd), 64'h7);
        rdi = 6'h00;
        tick(2);
        chk("prio_rd_rst", 64'(prd), 64'(`PRIO_RST));
        rdi = 6'h3c;
        tick(2);
        chk("prio_rd_out", 64'(prd), 64'h0);
    endtask
    task automatic t_pend();
        evt = '1;
        tick();
        evt = '0;
        tick();
        chk("pend_all", 64'(pend), 64'(`IMPL_MASK));
        chk("pend_lvd", 64'({pend[50], pend[42]}), 64'h1);
        pulse_clear_all();
        chk("pend_clr", 64'(pend), 64'h0);
        evt[3] = 1'b1;
        clr[3] = 1'b1;
        tick();
        {evt[3], clr[3]} = 2'b00;
        tick(3);
        chk("set_beats_clr", 64'(pend), 64'h8);
        pulse_clear_all();
    endtask
    task automatic t_arb();
        en = '1;
        wrp(6'h05, 4'h3);
        wrp(6'h02, 4'h3);
        ipl = 3'h1;
        evt[5] = 1'b1;
        evt[2] = 1'b1;
        tick();
        evt = '0;
        tick(3);
        chk("tie_num", 64'({req, num}), 64'({1'b1, 6'h02}));
        chk("tie_vec", 64'(vec), 64'h0a);
        chk("tie_addr", 64'(vad), 64'(`VT_BASE + 24'h000014));
        wrp(6'h2a, 4'h7);
        evt[42] = 1'b1;
        tick();
        evt = '0;
        tick(3);
        chk("lvl_num", 64'({num, vec}), 64'({6'h2a, 7'h32}));
        ctl.alt_table_select = 1'b1;
        trap = 3'h3;
        tick(3);
        chk("alt_addr", 64'(vad), 64'(`VT_BASE + `ALT_OFS + 24'h000064));
        chk("alt_trap", 64'(tad), 64'(`VT_BASE + `ALT_OFS + 24'h000006));
        ipl = 3'h7;
        tick(3);
        chk("ipl_block", 64'(req), 64'h0);
        ipl = 3'h2;
        wrp(6'h2a, 4'h0);
        wrp(6'h05, 4'h2);
        tick(3);
        chk("lvl_low", 64'({req, num}), 64'({1'b1, 6'h02}));
        ctl.alt_table_select = 1'b0;
        ipl = '0;
        pulse_clear_all();
        en = '0;
    endtask
    task automatic t_ext();
        ctl.external_edge_polarity_bits = 3'b010;
        ext = 3'b011;
        tick(3);
        chk("ext_rise", 64'(pend), 64'h1);
        pulse_clear_all();
        tick(3);
        chk("ext_level", 64'(pend), 64'h0);
        ext = 3'b000;
        tick(3);
        chk("ext_fall", 64'(pend), 64'(54'h1 << 16));
        pulse_clear_all();
        ctl.external_edge_polarity_bits = 3'b000;
        ext = 3'b100;
        tick(3);
        chk("ext2_rise", 64'(pend), 64'(54'h1 << 23));
        ext = 3'b000;
        pulse_clear_all();
    endtask
    task automatic t_bus();
        mev = 1'b1;
        tick();
        mev = 1'b0;
        sev = 1'b1;
        chk("bus_master", 64'(pend), 64'(54'h1 << 14));
        tick();
        sev = 1'b0;
        chk("bus_slave", 64'(pend), 64'(54'h3 << 13));
        pulse_clear_all();
    endtask
    task automatic t_shadow();
        flg = 5'h15;
        wrg = 64'h0123_4567_89ab_cdef;
        push = 1'b1;
        tick();
        push = 1'b0;
        flg = 5'h0a;
        wrg = '0;
        tick(2);
        chk("shadow_flags", 64'(sfl), 64'h15);
        chk("shadow_regs", 64'(srg), 64'h0123_4567_89ab_cdef);
        pop = 1'b1;
        tick();
        pop = 1'b0;
        chk("restore_on", 64'(rsto), 64'h1);
        tick();
        chk("restore_off", 64'(rsto), 64'h0);
    endtask
    task automatic t_wake();
        int i;
        en[3] = 1'b1;
        gsl = 1'b1;
        tick();
        gsl = 1'b0;
        tick(3);
        chk("asleep", 64'(slp), 64'h1);
        evt[3] = 1'b1;
        tick();
        evt[3] = 1'b0;
        for (i = 0; i < 8 && slp; i++)
            tick();
        chk("wake_in_time", 64'(slp), 64'h0);
        if (slp)
            return;
        chk("woken_req", 64'(req), 64'h1);
        pulse_clear_all();
        idle = 1'b1;
        evt[3] = 1'b1;
        tick();
        evt[3] = 1'b0;
        tick(3);
        chk("idle_wake", 64'(wake), 64'h1);
        idle = 1'b0;
        en = '0;
        pulse_clear_all();
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        tick(16);
        rst_n = 1'b1;
        tick(2);
        chk("rst_pend", 64'(pend), 64'h0);
        t_prio();
        t_pend();
        t_arb();
        t_ext();
        t_bus();
        t_shadow();
        t_wake();
        stop_test();
    end
endmodule // prioritized_interrupt_controller_test
`default_nettype wire
